// file: rtl/sms_defines.svh
// How it works
// - run mode accepts only 0 to 4, 6 and 7; resets to 0
// - startup selection 1 or 2 boots into network unless run mode forces
// - startup selection 2 or 12 restores pre-outage mode after outage
// - selection 10 or 12 boots network for run 0,2,6; panel key toggles panel/network
// - both settings are writable only while the motor is stopped
// - selection 0: external for run 0,2,6,7, panel for run 1
// - selection 0 run 2: external/network switching only, panel refused
// - run 3 or 4: combined mode, all changes refused
// - run 1: panel unit mode, fixed
// - run 7 with output stop off: forced and held external
// - run 6: switching allowed while the motor runs
// - selection 1 or 2: network for run 0,2,6; run 7 by stop
// - selection 10 or 12 run 0: network boot, panel/network switching
// - selection 10 or 12: run 2 fixed network, run 7 external
// - coast time other than 9999 resumes running after outage
// - no direct panel to network move, or back, unless allowed
// - priority: run mode, stop, net/ext, panel/net, ext/panel, startup
// - selection 10 or 12: panel/net input on panel, off network
`ifndef SMS_DEFINES_SVH
`define SMS_DEFINES_SVH

// register byte offsets
`define SMS_OFF_RUN_MODE 8'h00
`define SMS_OFF_COMM_START 8'h04
`define SMS_OFF_COAST_TIME 8'h08
`define SMS_OFF_MODE_REQ 8'h0c
`define SMS_OFF_STATUS 8'h10

// reset values
`define SMS_RST_RUN_MODE 8'h00
`define SMS_RST_COMM_START 8'h00
`define SMS_RST_COAST_TIME 16'h270f

// coast time value that disables restart
`define SMS_COAST_OFF 16'h270f

// run mode codes
`define SMS_RM_0 8'h00
`define SMS_RM_1 8'h01
`define SMS_RM_2 8'h02
`define SMS_RM_3 8'h03
`define SMS_RM_4 8'h04
`define SMS_RM_6 8'h06
`define SMS_RM_7 8'h07

// startup selection codes
`define SMS_CS_0 8'h00
`define SMS_CS_1 8'h01
`define SMS_CS_2 8'h02
`define SMS_CS_10 8'h0a
`define SMS_CS_12 8'h0c

// status field positions
`define SMS_ST_MODE_LO 0
`define SMS_ST_SAVED_LO 2
`define SMS_ST_REFUSED 4
`define SMS_ST_FIXED 5
`define SMS_ST_RUNNING 6

`endif

// file: rtl/sms_pkg.sv
package sms_pkg;

  // operation modes
  typedef enum logic [1:0] {
    SMS_EXT,
    SMS_PU,
    SMS_NET,
    SMS_COMB
  } sms_mode_e;

  // pin inputs from outside the clock domain
  typedef struct packed {
    logic output_stop_pin;
    logic network_external_switch_input;
    logic panel_network_switch_input;
    logic external_panel_switch_input;
    logic panel_key;
    logic power_outage;
  } sms_pins_s;

endpackage

// file: rtl/sms_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sms_sync #(
  parameter int W = 6
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw and settled levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // three stage chain per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          s1[i] <= din[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            dout[i] <= s3[i]; // settled once stages two and three agree
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// file: rtl/sms_mode_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "sms_defines.svh"
module sms_mode_select
  import sms_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive state and pins
  input wire logic motor_running,
  input wire sms_pins_s pins,
  // mode result
  output sms_mode_e active_mode,
  output logic resume_run
);

  // ==========================================================
  // declarations
  // ==========================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic [7:0] run_mode_selection;
  logic [7:0] comm_startup_selection;
  logic [15:0] restart_coast_time;
  sms_pins_s pin_s;
  sms_pins_s pin_q;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_en;
  logic wr_ok;
  logic sw_req;
  sms_mode_e sw_target;
  sms_mode_e saved_mode;
  logic was_running;
  logic boot;
  logic refused;
  logic refuse_evt;
  logic restore_evt;
  logic stop_ok;
  logic req_valid;
  sms_mode_e req_target;
  logic force_valid;
  sms_mode_e force_mode;
  logic [31:0] status_word;

  // settle pin inputs
  sms_sync #(.W($bits(sms_pins_s))) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(pins),
    .dout(pin_s)
  );

  // ==========================================================
  // mode helpers
  // ==========================================================
  function automatic logic cs_net(input logic [7:0] cs);
    return cs == `SMS_CS_1 || cs == `SMS_CS_2;
  endfunction

  function automatic logic cs_panel(input logic [7:0] cs);
    return cs == `SMS_CS_10 || cs == `SMS_CS_12;
  endfunction

  function automatic logic valid_rm(input logic [7:0] v);
    return v == `SMS_RM_0 || v == `SMS_RM_1 || v == `SMS_RM_2 ||
           v == `SMS_RM_3 || v == `SMS_RM_4 || v == `SMS_RM_6 ||
           v == `SMS_RM_7;
  endfunction

  function automatic logic valid_cs(input logic [7:0] v);
    return v == `SMS_CS_0 || cs_net(v) || cs_panel(v);
  endfunction

  // mode entered at power on, restoration or reset
  function automatic sms_mode_e startup_mode(input logic [7:0] rm,
                                             input logic [7:0] cs,
                                             input logic stp);
    if (rm == `SMS_RM_1) begin
      return SMS_PU;
    end
    if (rm == `SMS_RM_3 || rm == `SMS_RM_4) begin
      return SMS_COMB;
    end
    if (rm == `SMS_RM_7) begin
      return (stp && cs_net(cs)) ? SMS_NET : SMS_EXT;
    end
    if (cs_net(cs) || cs_panel(cs)) begin
      return SMS_NET;
    end
    return SMS_EXT;
  endfunction

  // whether a change from cur to tgt may happen now
  function automatic logic may_switch(input sms_mode_e cur,
                                      input sms_mode_e tgt,
                                      input logic [7:0] rm,
                                      input logic [7:0] cs,
                                      input logic stp);
    logic pu_net;
    logic ext_net;
    pu_net = (cur == SMS_PU || cur == SMS_NET) &&
             (tgt == SMS_PU || tgt == SMS_NET);
    ext_net = (cur != SMS_PU) && (tgt == SMS_EXT || tgt == SMS_NET);
    if (tgt == cur || tgt == SMS_COMB) begin
      return 1'b0;
    end
    if (rm == `SMS_RM_1 || rm == `SMS_RM_3 || rm == `SMS_RM_4) begin
      return 1'b0;
    end
    if (rm == `SMS_RM_7 && !stp) begin
      return 1'b0;
    end
    if (cs_panel(cs)) begin
      if (rm == `SMS_RM_2) begin
        return 1'b0;
      end
      return pu_net;
    end
    if (rm == `SMS_RM_2) begin
      return ext_net;
    end
    return !pu_net;
  endfunction

  // mode imposed by the settings regardless of requests
  always_comb begin
    force_valid = 1'b1;
    force_mode = SMS_EXT;
    if (run_mode_selection == `SMS_RM_1) begin
      force_mode = SMS_PU;
    end else if (run_mode_selection == `SMS_RM_3 ||
                 run_mode_selection == `SMS_RM_4) begin
      force_mode = SMS_COMB;
    end else if (run_mode_selection == `SMS_RM_7 &&
                 !pin_s.output_stop_pin) begin
      force_mode = SMS_EXT;
    end else if (run_mode_selection == `SMS_RM_2 &&
                 cs_panel(comm_startup_selection)) begin
      force_mode = SMS_NET;
    end else begin
      force_valid = 1'b0;
    end
  end

  // pick one switch request by signal priority
  always_comb begin
    req_valid = 1'b1;
    req_target = SMS_EXT;
    if (pin_s.network_external_switch_input !=
        pin_q.network_external_switch_input) begin
      req_target = pin_s.network_external_switch_input ?
                   SMS_NET : SMS_EXT;
    end else if (pin_s.panel_network_switch_input !=
                 pin_q.panel_network_switch_input &&
                 cs_panel(comm_startup_selection)) begin
      req_target = pin_s.panel_network_switch_input ?
                   SMS_PU : SMS_NET;
    end else if (pin_s.external_panel_switch_input !=
                 pin_q.external_panel_switch_input) begin
      req_target = pin_s.external_panel_switch_input ?
                   SMS_EXT : SMS_PU;
    end else if (pin_s.panel_key && !pin_q.panel_key &&
                 cs_panel(comm_startup_selection)) begin
      req_target = (active_mode == SMS_PU) ? SMS_NET : SMS_PU;
    end else if (sw_req) begin
      req_target = sw_target;
    end else begin
      req_valid = 1'b0;
    end
  end

  assign stop_ok = !motor_running ||
                   run_mode_selection == `SMS_RM_6;
  assign restore_evt = pin_q.power_outage && !pin_s.power_outage;

  // ==========================================================
  // operation mode
  // ==========================================================
  // delayed pin levels for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= '0;
    end else begin
      pin_q <= pin_s;
    end
  end

  // active mode: boot, restore, force, then requests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_mode <= SMS_EXT;
      boot <= 1'b1;
    end else if (boot) begin
      boot <= 1'b0;
      active_mode <= startup_mode(run_mode_selection,
                                  comm_startup_selection,
                                  pin_s.output_stop_pin);
    end else if (restore_evt) begin
      if (force_valid) begin
        active_mode <= force_mode;
      end else if (comm_startup_selection == `SMS_CS_2 ||
                   comm_startup_selection == `SMS_CS_12) begin
        active_mode <= saved_mode;
      end else begin
        active_mode <= startup_mode(run_mode_selection,
                                    comm_startup_selection,
                                    pin_s.output_stop_pin);
      end
    end else if (force_valid) begin
      active_mode <= force_mode;
    end else if (req_valid && stop_ok &&
                 may_switch(active_mode, req_target,
                            run_mode_selection, comm_startup_selection,
                            pin_s.output_stop_pin)) begin
      active_mode <= req_target;
    end
  end

  assign refuse_evt = !boot && !restore_evt && !force_valid &&
                      req_valid && req_target != active_mode &&
                      (!stop_ok ||
                       !may_switch(active_mode, req_target,
                                   run_mode_selection,
                                   comm_startup_selection,
                                   pin_s.output_stop_pin));

  // pre-outage mode and run state, frozen during an outage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      saved_mode <= SMS_EXT;
      was_running <= 1'b0;
    end else if (!pin_s.power_outage && !restore_evt) begin
      saved_mode <= active_mode;
      was_running <= motor_running;
    end
  end

  // restart pulse after an outage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume_run <= 1'b0;
    end else begin
      resume_run <= restore_evt && was_running &&
                    restart_coast_time != `SMS_COAST_OFF;
    end
  end

  // ==========================================================
  // axi4-lite write side
  // ==========================================================
  assign wr_en = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_ok = (aw_addr == `SMS_OFF_RUN_MODE &&
                  valid_rm(w_data[7:0]) && !motor_running) ||
                 (aw_addr == `SMS_OFF_COMM_START &&
                  valid_cs(w_data[7:0]) && !motor_running) ||
                 aw_addr == `SMS_OFF_COAST_TIME ||
                 aw_addr == `SMS_OFF_MODE_REQ ||
                 aw_addr == `SMS_OFF_STATUS;

  // address and data taken in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_hold <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_hold <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // setting registers, stopped-motor writes only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_mode_selection <= `SMS_RST_RUN_MODE;
      comm_startup_selection <= `SMS_RST_COMM_START;
    end else if (wr_en && wr_ok && w_strb[0]) begin
      if (aw_addr == `SMS_OFF_RUN_MODE) begin
        run_mode_selection <= w_data[7:0];
      end
      if (aw_addr == `SMS_OFF_COMM_START) begin
        comm_startup_selection <= w_data[7:0];
      end
    end
  end

  // coast time, one enable per byte lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart_coast_time <= `SMS_RST_COAST_TIME;
    end else if (wr_en && aw_addr == `SMS_OFF_COAST_TIME) begin
      if (w_strb[0]) begin
        restart_coast_time[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        restart_coast_time[15:8] <= w_data[15:8];
      end
    end
  end

  // software mode request pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_req <= 1'b0;
      sw_target <= SMS_EXT;
    end else begin
      sw_req <= wr_en && aw_addr == `SMS_OFF_MODE_REQ && w_strb[0];
      sw_target <= sms_mode_e'(w_data[1:0]);
    end
  end

  // sticky refusal flag, set wins over write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused <= 1'b0;
    end else if (refuse_evt) begin
      refused <= 1'b1;
    end else if (wr_en && aw_addr == `SMS_OFF_STATUS && w_strb[0] &&
                 w_data[`SMS_ST_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  // ==========================================================
  // axi4-lite read side
  // ==========================================================
  always_comb begin
    status_word = 32'h0;
    status_word[`SMS_ST_MODE_LO +: 2] = active_mode;
    status_word[`SMS_ST_SAVED_LO +: 2] = saved_mode;
    status_word[`SMS_ST_REFUSED] = refused;
    status_word[`SMS_ST_FIXED] = force_valid;
    status_word[`SMS_ST_RUNNING] = motor_running;
  end

  // one read at a time, data one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        `SMS_OFF_RUN_MODE: s_axi_rdata <= {24'h0, run_mode_selection};
        `SMS_OFF_COMM_START:
          s_axi_rdata <= {24'h0, comm_startup_selection};
        `SMS_OFF_COAST_TIME: s_axi_rdata <= {16'h0, restart_coast_time};
        `SMS_OFF_MODE_REQ: s_axi_rdata <= 32'h0;
        `SMS_OFF_STATUS: s_axi_rdata <= status_word;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: dv/sms_mode_select_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sms_mode_select_props
  import sms_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite handshakes
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and mode result
  input wire sms_pins_s pins,
  input wire sms_mode_e active_mode,
  input wire logic resume_run
);
  // ==========================================
  // shadow copies of the accepted settings
  logic [7:0] wa;
  logic [7:0] wd;
  logic [7:0] rm_sh;
  logic [7:0] cs_sh;

  // latch address and data as they are taken
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
  end

  // update while an okay response stands, one cycle behind the register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rm_sh <= 8'h00;
      cs_sh <= 8'h00;
    end else if (s_axi_bvalid && s_axi_bresp == 2'h0) begin
      if (wa == 8'h00) rm_sh <= wd;
      if (wa == 8'h04) cs_sh <= wd;
    end
  end

  // ==========================================
  // properties
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  aw_once_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address taken twice");
  b_after_both_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_next_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  pu_fixed_a: assert property (
    rm_sh == 8'h01 |-> active_mode == SMS_PU)
    else $error("run mode 1 left panel mode");
  comb_fixed_a: assert property (
    rm_sh inside {8'h03, 8'h04} |-> active_mode == SMS_COMB)
    else $error("run mode 3 or 4 left combined mode");
  ext_forced_a: assert property (
    (rm_sh == 8'h07 && !pins.output_stop_pin) [*6] |-> active_mode == SMS_EXT)
    else $error("run mode 7 not held external");
  net_fixed_a: assert property (
    rm_sh == 8'h02 && cs_sh inside {8'h0a, 8'h0c} |-> active_mode == SMS_NET)
    else $error("run mode 2 left network mode");
  resume_pulse_a: assert property (resume_run |=> !resume_run)
    else $error("resume longer than one cycle");

  // main scenarios reached
  cover property (active_mode == SMS_PU);
  cover property (active_mode == SMS_COMB);
  cover property (resume_run);
endmodule

bind sms_mode_select sms_mode_select_props sms_mode_select_props_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pins(pins), .active_mode(active_mode),
  .resume_run(resume_run)
);
`default_nettype wire

// file: dv/tb_sms_mode_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sms_mode_select
  import sms_pkg::*;
  ;
  // ==========================================
  // signals
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, motor_running, resume_run;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, v8;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd, rnd, rm_exp;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  sms_pins_s pins;
  sms_mode_e active_mode;
  int mismatches, checks_done, p;
  int csl[3] = '{0, 1, 10};
  int rml[7] = '{0, 1, 2, 3, 4, 6, 7};

  // 200 mhz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  sms_mode_select sms_mode_select_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .motor_running(motor_running),
    .pins(pins), .active_mode(active_mode), .resume_run(resume_run));

  // ==========================================
  // expectation helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic rm_ok(input logic [7:0] v);
    return v <= 8'h04 || v == 8'h06 || v == 8'h07;
  endfunction

  function automatic sms_mode_e boot_mode(input int cs, input int rm,
                                          input logic stp);
    if (rm == 1) return SMS_PU;
    if (rm == 3 || rm == 4) return SMS_COMB;
    if (rm == 7 && (!stp || cs >= 10)) return SMS_EXT;
    if (cs == 0) return SMS_EXT;
    return SMS_NET;
  endfunction

  // ==========================================
  // bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  task automatic cm(input sms_mode_e e);
    chk("active_mode", {30'h0, e}, {30'h0, active_mode});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    rs = 2'bxx;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_bready && s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
  endtask

  task automatic rdr(input logic [7:0] a);
    rs = 2'bxx;
    rd = 32'hxxxxxxxx;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
      end else if (s_axi_rready && s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end else if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b1;
      end
    end
  endtask

  // mode request, then let it land
  task automatic req(input sms_mode_e m);
    wr(8'h0c, {30'h0, m});
    repeat (4) @(posedge aclk);
  endtask

  // outage pulse, counting resume pulses after it
  task automatic outage();
    p = 0;
    pins.power_outage <= 1'b1;
    repeat (8) @(posedge aclk);
    pins.power_outage <= 1'b0;
    repeat (14) begin
      @(posedge aclk);
      if (resume_run === 1'b1) p++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================
  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    test_done();
  end

  // main sequence
  initial begin
    seed = 32'h0000082a;
    mismatches = 0;
    checks_done = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, motor_running} = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    pins = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(8'h00);
    chk("run_mode", 32'h0, rd);
    rdr(8'h04);
    chk("comm_startup", 32'h0, rd);
    rdr(8'h40);
    chk("unmapped_resp", 32'h2, {30'h0, rs});
    for (int v = 0; v < 16; v++) begin
      wr(8'h00, v);
      chk("run_mode_resp", rm_ok(v[7:0]) ? 32'h0 : 32'h2, {30'h0, rs});
      wr(8'h04, v);
      chk("comm_resp", v inside {0, 1, 2, 10, 12} ? 0 : 2, {30'h0, rs});
    end
    rm_exp = 32'h7;
    for (int i = 0; i < 12; i++) begin
      rnd = xs();
      v8 = {4'h0, rnd[3:0]};
      wr(8'h00, {24'h0, v8});
      if (rm_ok(v8)) rm_exp = {24'h0, v8};
      rdr(8'h00);
      chk("run_mode_rand", rm_exp, rd);
    end
    foreach (csl[i]) begin
      wr(8'h04, csl[i]);
      foreach (rml[j]) begin
        for (int s = 0; s < 2; s++) begin
          pins.output_stop_pin <= s[0];
          wr(8'h00, rml[j]);
          outage();
          cm(boot_mode(csl[i], rml[j], s[0]));
        end
      end
    end
    wr(8'h04, 0);
    wr(8'h00, 0);
    wr(8'h08, 32'h5);
    motor_running <= 1'b1;
    outage();
    motor_running <= 1'b0;
    chk("resume_pulses", 1, p);
    wr(8'h08, 32'h270f);
    motor_running <= 1'b1;
    outage();
    motor_running <= 1'b0;
    chk("resume_pulses", 0, p);
    wr(8'h04, 1);
    outage();
    cm(SMS_NET);
    wr(8'h04, 2);
    req(SMS_EXT);
    outage();
    cm(SMS_EXT);
    wr(8'h04, 10);
    outage();
    pins.panel_network_switch_input <= 1'b1;
    repeat (8) @(posedge aclk);
    cm(SMS_PU);
    pins.panel_network_switch_input <= 1'b0;
    repeat (8) @(posedge aclk);
    cm(SMS_NET);
    pins.panel_key <= 1'b1;
    repeat (8) @(posedge aclk);
    cm(SMS_PU);
    pins.panel_key <= 1'b0;
    wr(8'h04, 0);
    outage();
    pins.network_external_switch_input <= 1'b1;
    repeat (8) @(posedge aclk);
    cm(SMS_NET);
    req(SMS_PU);
    cm(SMS_NET);
    rdr(8'h10);
    chk("refused", 32'h1, {31'h0, rd[4]});
    pins.network_external_switch_input <= 1'b0;
    wr(8'h10, 32'h10);
    wr(8'h00, 2);
    repeat (8) @(posedge aclk);
    req(SMS_PU);
    cm(SMS_EXT);
    wr(8'h00, 6);
    motor_running <= 1'b1;
    req(SMS_NET);
    cm(SMS_NET);
    wr(8'h00, 0);
    chk("busy_resp", 32'h2, {30'h0, rs});
    motor_running <= 1'b0;
    wr(8'h00, 0);
    motor_running <= 1'b1;
    req(SMS_EXT);
    cm(SMS_NET);
    motor_running <= 1'b0;
    test_done();
  end
endmodule
`default_nettype wire
